// File: bench/qm_chk_sva.sv
// Checker for the monitor's lamp and marker outputs.
// Sees only qm_monitor ports; bound below with the same lamp length.
`timescale 1ns/1ns
`default_nettype none
module qm_chk #(
   parameter LED_CYC = 20
) (
   input wire clock,
   input wire rstn,
   input wire frame_mark_q,
   input wire frame_start_out_q,
   input wire frame_end_q,
   input wire fs_led,
   input wire parity_led,
   input wire seq_led,
   input wire drop_led
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // A lamp goes dark only after a full stretch of high cycles
   fs_len_a: assert property ($fell(fs_led) |-> $past(fs_led, LED_CYC)) else $error("short start lamp");
   par_len_a: assert property ($fell(parity_led) |-> $past(parity_led, LED_CYC)) else $error("short lamp");
   seq_len_a: assert property ($fell(seq_led) |-> $past(seq_led, LED_CYC)) else $error("short count lamp");
   drop_len_a: assert property ($fell(drop_led) |-> $past(drop_led, LED_CYC)) else $error("short drop lamp");
   start_len_a: assert property ($rose(frame_start_out_q) |->
      frame_start_out_q[*8] ##1 frame_start_out_q[*2] ##1 !frame_start_out_q) else $error("start pulse width");
   start_mark_a: assert property (frame_start_out_q |-> frame_mark_q) else $error("marker low at start");
   end_excl_a: assert property (frame_end_q |-> !frame_start_out_q) else $error("end marker at start");
   start_ok_a: assert property ($rose(frame_start_out_q) |-> !$rose(fs_led)) else $error("error on found");
   cover property ($rose(fs_led));
   cover property ($rose(frame_start_out_q));
   cover property ($fell(fs_led));
endmodule // qm_chk
bind qm_monitor qm_chk #(.LED_CYC(LED_CYC)) u_qm_chk (.clock(clock), .rstn(rstn), .frame_mark_q(frame_mark_q),
   .frame_start_out_q(frame_start_out_q), .frame_end_q(frame_end_q), .fs_led(fs_led),
   .parity_led(parity_led), .seq_led(seq_led), .drop_led(drop_led));
`default_nettype wire

// File: bench/qm_recorder.sv
// Recorder and format reference model: 60 Hz edge and video bits.
// Driven by tasks called from the bench; changes follow rising edges.
`timescale 1ns/1ns
`default_nettype none
module qm_recorder (
   input wire logic clock,
   output logic ref_60hz_pin,
   output logic headswitch_pin,
   output logic vid_clk_pin,
   output logic vid_data_pin
);
   // Idle: bit clock stands still, data shows no stale bit
   initial begin
      ref_60hz_pin = 1'b0;
      headswitch_pin = 1'b0;
      vid_clk_pin = 1'b0;
      vid_data_pin = 1'b1;
   end
   task ref_edge;
      begin
         ref_60hz_pin <= 1'b1;
         repeat (50) @(posedge clock);
         ref_60hz_pin <= 1'b0;
      end
   endtask
   // bits MSB first, clock runs only within the burst
   task send(input logic [7:0] b);
      integer i;
      begin
         for (i = 7; i >= 0; i--) begin
            vid_data_pin <= b[i];
            repeat (4) @(posedge clock);
            vid_clk_pin <= 1'b1;
            repeat (4) @(posedge clock);
            vid_clk_pin <= 1'b0;
         end
         // Released line shows the inverse of the last bit
         vid_data_pin <= ~b[0];
      end
   endtask
endmodule // qm_recorder
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench: AXI4-Lite register tasks plus recorder model.
// Assumes shortened timing, so one second is 1000 cycles here.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, rd_d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] rd_r;
   logic aud_clk_pin = 0, aud_data_pin = 0, aud_sync_pin = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire vid_clk_pin, vid_data_pin, ref_60hz_pin, headswitch_pin;
   wire aud_track2_q, data_out_q, frame_mark_q, frame_start_out_q, frame_end_q;
   wire fs_led, parity_led, seq_led, drop_led;
   integer mismatches = 0, comparisons = 0, cycles = 0, n = 0;
   qm_monitor #(.LED_CYC(20), .REFWIN_CYC(200), .RAWDLY_CYC(50), .BLANK_CYC(10), .SEC_CYC(1000)) u_qm_monitor (
      .clock(clock), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .vid_clk_pin(vid_clk_pin), .vid_data_pin(vid_data_pin), .ref_60hz_pin(ref_60hz_pin),
      .headswitch_pin(headswitch_pin), .aud_clk_pin(aud_clk_pin), .aud_data_pin(aud_data_pin),
      .aud_sync_pin(aud_sync_pin),
      .aud_track2_q(aud_track2_q), .data_out_q(data_out_q), .frame_mark_q(frame_mark_q),
      .frame_start_out_q(frame_start_out_q), .frame_end_q(frame_end_q), .fs_led(fs_led),
      .parity_led(parity_led), .seq_led(seq_led), .drop_led(drop_led));
   qm_recorder u_qm_recorder (.clock(clock), .ref_60hz_pin(ref_60hz_pin), .headswitch_pin(headswitch_pin),
      .vid_clk_pin(vid_clk_pin), .vid_data_pin(vid_data_pin));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Cut a hang short well after the planned 72k cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         tally_and_finish;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         comparisons++;
         if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %0h, expected %0h", $time, g, e);
         end
      end
   endtask
   // Address and data offered together, each dropped when taken
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic aw, w;
      begin
         aw = 0;
         w = 0;
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         while (!(aw && w)) begin
            @(posedge clock);
            if (s_axi_awready) begin
               aw = 1;
               s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready) begin
               w = 1;
               s_axi_wvalid <= 1'b0;
            end
         end
         while (!s_axi_bvalid) @(posedge clock);
         s_axi_bready <= 1'b0;
         chk(s_axi_bresp, e);
         repeat (2) @(posedge clock);
      end
   endtask
   task rd(input logic [7:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do @(posedge clock); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         while (!s_axi_rvalid) @(posedge clock);
         rd_d = s_axi_rdata;
         rd_r = s_axi_rresp;
         s_axi_rready <= 1'b0;
         @(posedge clock);
      end
   endtask
   task tallies(input logic [31:0] f);
      begin
         rd(8'h08);
         chk(rd_d, f);
         rd(8'h0c);
         chk(rd_d, 32'h0);
         rd(8'h10);
         chk(rd_d, 32'h0);
      end
   endtask
   // Interval restarts on release of the restart bit
   task restart(input logic [31:0] c);
      begin
         wr(8'h00, c | 32'h8, 2'h0);
         wr(8'h00, c, 2'h0);
      end
   endtask
   // Reference edge with no frame start: error only after the window
   task ref_miss;
      begin
         u_qm_recorder.ref_edge;
         repeat (140) @(posedge clock);
         chk(fs_led, 1'h0);
         repeat (90) if (!fs_led) @(posedge clock);
         chk(fs_led, 1'h1);
         repeat (100) @(posedge clock);
      end
   endtask
   task tally_and_finish;
      begin
         $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
         if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   initial begin
      rstn = 1'b0;
      s_axi_awaddr = 8'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (10) @(posedge clock);
      chk(frame_mark_q, 1'h1);
      rstn <= 1'b1;
      @(posedge clock);
      rd(8'h00);
      chk(rd_d, 32'h0);
      tallies(32'h0);
      rd(8'h20);
      chk(rd_r, 2'h2);
      wr(8'h04, 32'h0, 2'h2);
      wr(8'h00, 32'h4, 2'h0);
      chk(aud_track2_q, 1'h1);
      restart(32'h0);
      chk(aud_track2_q, 1'h0);
      aud_data_pin <= 1'b1;
      repeat (8) begin
         aud_clk_pin <= ~aud_clk_pin;
         repeat (4) @(posedge clock);
      end
      aud_sync_pin <= 1'b1;
      repeat (4) @(posedge clock);
      rd(8'h14);
      chk(rd_d, 32'hf);
      $display("test reset, map and track select done");
      ref_miss;
      ref_miss;
      repeat (450) @(posedge clock);
      tallies(32'h2);
      restart(32'h10);
      repeat (1100) @(posedge clock);
      tallies(32'h2);
      repeat (9000) @(posedge clock);
      tallies(32'h0);
      restart(32'h22);
      ref_miss;
      repeat (9800) @(posedge clock);
      tallies(32'h0);
      repeat (50000) @(posedge clock);
      tallies(32'h1);
      $display("test interval lengths done");
      fork
         u_qm_recorder.ref_edge;
         u_qm_recorder.send(8'h05);
         repeat (90) begin
            @(posedge clock);
            n = n + frame_start_out_q;
         end
      join
      chk(n, 32'ha);
      chk(data_out_q, 1'h1);
      chk(frame_mark_q, 1'h1);
      repeat (200) @(posedge clock);
      chk(fs_led, 1'h0);
      $display("test frame start done");
      tally_and_finish;
   end
endmodule // tb
`default_nettype wire

// File: common/qm_defines.vh
// Constants for the tape frame error monitor: register map, fields, timing.
// Assumes a 100 MHz core clock; included by bare name from the rtl files.
`ifndef QM_DEFINES_VH
`define QM_DEFINES_VH

// Clock period in ns
`define QM_CLK_NS 10
// Register byte offsets
`define QM_REG_CTRL 8'h00
`define QM_REG_STAT 8'h04
`define QM_REG_FS_TALLY 8'h08
`define QM_REG_SEQ_TALLY 8'h0c
`define QM_REG_DROP_TALLY 8'h10
`define QM_REG_AUD_LO 8'h14
`define QM_REG_AUD_HI 8'h18
`define QM_REG_LAST_SEQ 8'h1c
// Control fields
`define QM_CTRL_HS_FMT 0
`define QM_CTRL_RAW 1
`define QM_CTRL_TRACK2 2
`define QM_CTRL_RESTART 3
`define QM_CTRL_IVL_LO 4
`define QM_CTRL_IVL_HI 5
`define QM_CTRL_RESET 6'h00
// Interval selector codes and lengths in seconds
`define QM_IVL_1S 2'h0
`define QM_IVL_10S 2'h1
`define QM_IVL_60S 2'h2
`define QM_SECS_1 6'h01
`define QM_SECS_10 6'h0a
`define QM_SECS_60 6'h3c
// Tally ceiling and sequence modulus
`define QM_TALLY_MAX 10'h3e7
`define QM_SEQ_MOD 6'h3c
// Times in ns as printed, and their cycle counts
`define QM_LED_NS 8000000
`define QM_LED_CYC ((`QM_LED_NS + `QM_CLK_NS - 1) / `QM_CLK_NS)
`define QM_FSPULSE_NS 100
`define QM_FSPULSE_CYC ((`QM_FSPULSE_NS + `QM_CLK_NS - 1) / `QM_CLK_NS)
`define QM_REFWIN_NS 1300000
`define QM_REFWIN_CYC (`QM_REFWIN_NS / `QM_CLK_NS)
`define QM_RAWDLY_NS 5600000
`define QM_RAWDLY_CYC (`QM_RAWDLY_NS / `QM_CLK_NS)
`define QM_BLANK_NS 45000
`define QM_BLANK_CYC ((`QM_BLANK_NS + `QM_CLK_NS - 1) / `QM_CLK_NS)
`define QM_SEC_CYC 100000000
// Headswitch search: bits after first zero, window width in bits
`define QM_HS_SKIP 5'd31
`define QM_HS_WIN 3'd4
// Frame layout in bits
`define QM_FS_PATTERN 3'h5
`define QM_SYNC_WORD 8'ha7
`define QM_SYNC_GAP 14'd256
`define QM_FRAME_BITS 14'd8192
`define QM_EOF_BITS 14'd64
`define QM_SEQ_END 14'd23
// Frame count carries odd parity
`define QM_SEQ_PARITY 1'b1

`endif

// File: rtl/qm_monitor.v
// Tape frame error monitor: frame-start search, error checks, tallies, AXI4-Lite registers.
// Assumes recovered bit clock, data and audio signals arrive as asynchronous pins.
`timescale 1ns/1ns
`default_nettype none
`include "qm_defines.vh"
module qm_monitor #(
   parameter LED_CYC = `QM_LED_CYC,
   parameter REFWIN_CYC = `QM_REFWIN_CYC,
   parameter RAWDLY_CYC = `QM_RAWDLY_CYC,
   parameter BLANK_CYC = `QM_BLANK_CYC,
   parameter SEC_CYC = `QM_SEC_CYC
) (
   input wire clock,
   input wire rstn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire vid_clk_pin,
   input wire vid_data_pin,
   input wire ref_60hz_pin,
   input wire headswitch_pin,
   input wire aud_clk_pin,
   input wire aud_data_pin,
   input wire aud_sync_pin,
   output reg aud_track2_q,
   output reg data_out_q,
   output reg frame_mark_q,
   output reg frame_start_out_q,
   output reg frame_end_q,
   output wire fs_led,
   output wire parity_led,
   output wire seq_led,
   output wire drop_led
);
   // One-hot states of the frame-start search
   localparam S_IDLE = 7'h01;
   localparam S_DLY = 7'h02;
   localparam S_RWIN = 7'h04;
   localparam S_BLANK = 7'h08;
   localparam S_ZERO = 7'h10;
   localparam S_CNT = 7'h20;
   localparam S_HWIN = 7'h40;

   // Pin synchronisers: stage a feeds stage b only
   reg [6:0] sync_a_q;
   reg [6:0] sync_b_q;
   // Previous synced levels for edge detection
   reg vid_clk_prev_q, ref_prev_q, hs_prev_q, aud_clk_prev_q, aud_sync_prev_q;
   wire vid_clk_s = sync_b_q[0];
   wire vid_data_s = sync_b_q[1];
   wire ref_s = sync_b_q[2];
   wire hs_s = sync_b_q[3];
   wire aud_clk_s = sync_b_q[4];
   wire aud_data_s = sync_b_q[5];
   wire aud_sync_s = sync_b_q[6];
   wire bit_stb = vid_clk_s & ~vid_clk_prev_q;
   wire ref_edge = ref_s & ~ref_prev_q;
   wire hs_edge = hs_s ^ hs_prev_q;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync_a_q <= 7'h00;
         sync_b_q <= 7'h00;
         vid_clk_prev_q <= 1'b0;
         ref_prev_q <= 1'b0;
         hs_prev_q <= 1'b0;
         aud_clk_prev_q <= 1'b0;
         aud_sync_prev_q <= 1'b0;
      end else begin
         sync_a_q <= {aud_sync_pin, aud_data_pin, aud_clk_pin, headswitch_pin,
                      ref_60hz_pin, vid_data_pin, vid_clk_pin};
         sync_b_q <= sync_a_q;
         vid_clk_prev_q <= vid_clk_s;
         ref_prev_q <= ref_s;
         hs_prev_q <= hs_s;
         aud_clk_prev_q <= aud_clk_s;
         aud_sync_prev_q <= aud_sync_s;
      end
   end

   // Control register fields
   reg [5:0] ctrl_q;
   wire hs_fmt = ctrl_q[`QM_CTRL_HS_FMT];
   wire raw_sel = ctrl_q[`QM_CTRL_RAW];
   wire [1:0] ivl_sel = ctrl_q[`QM_CTRL_IVL_HI:`QM_CTRL_IVL_LO];

   // Bit shift register of the demodulated stream
   reg [7:0] shift_q;
   wire [7:0] shift_d = {shift_q[6:0], vid_data_s};
   wire fs_match = bit_stb & (shift_d[2:0] == `QM_FS_PATTERN);

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         shift_q <= 8'h00;
         data_out_q <= 1'b0;
      end else if (bit_stb) begin
         shift_q <= shift_d;
         data_out_q <= vid_data_s;
      end
   end

   // Frame-start search state and shared timer
   reg [6:0] st_q;
   reg [19:0] tmr_q;
   reg fs_err_q;
   reg fs_found_q;
   wire win_open = (st_q == S_RWIN) | (st_q == S_HWIN);
   wire fs_hit = win_open & fs_match;

   // format picks reference or headswitch path
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_q <= S_IDLE;
         tmr_q <= 20'h00000;
         fs_err_q <= 1'b0;
         fs_found_q <= 1'b0;
      end else begin
         fs_err_q <= 1'b0;
         fs_found_q <= fs_hit;
         case (st_q)
            S_IDLE: begin
               if (!hs_fmt && ref_edge && raw_sel) begin
                  // Read-after-write head trails, so the reference is delayed
                  st_q <= S_DLY;
                  tmr_q <= RAWDLY_CYC[19:0] - 20'h00001;
               end else if (!hs_fmt && ref_edge) begin
                  st_q <= S_RWIN;
                  tmr_q <= REFWIN_CYC[19:0] - 20'h00001;
               end else if (hs_fmt && hs_edge) begin
                  st_q <= S_BLANK;
                  tmr_q <= BLANK_CYC[19:0] - 20'h00001;
               end
            end
            S_DLY: begin
               if (tmr_q == 20'h00000) begin
                  st_q <= S_RWIN;
                  tmr_q <= REFWIN_CYC[19:0] - 20'h00001;
               end else begin
                  tmr_q <= tmr_q - 20'h00001;
               end
            end
            S_RWIN: begin
               if (fs_hit) begin
                  st_q <= S_IDLE;
               end else if (tmr_q == 20'h00000) begin
                  st_q <= S_IDLE;
                  fs_err_q <= 1'b1;
               end else begin
                  tmr_q <= tmr_q - 20'h00001;
               end
            end
            S_BLANK: begin
               // Headswitch noise is blanked before searching
               if (tmr_q == 20'h00000) begin
                  st_q <= S_ZERO;
               end else begin
                  tmr_q <= tmr_q - 20'h00001;
               end
            end
            S_ZERO: begin
               if (bit_stb && !vid_data_s) begin
                  st_q <= S_CNT;
                  tmr_q <= {15'h0000, `QM_HS_SKIP};
               end
            end
            S_CNT: begin
               if (bit_stb && tmr_q == 20'h00001) begin
                  st_q <= S_HWIN;
                  tmr_q <= {17'h00000, `QM_HS_WIN};
               end else if (bit_stb) begin
                  tmr_q <= tmr_q - 20'h00001;
               end
            end
            S_HWIN: begin
               if (fs_hit) begin
                  st_q <= S_IDLE;
               end else if (bit_stb && tmr_q == 20'h00001) begin
                  st_q <= S_IDLE;
                  fs_err_q <= 1'b1;
               end else if (bit_stb) begin
                  tmr_q <= tmr_q - 20'h00001;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // Bit position inside the frame and per-frame checks
   reg [13:0] pos_q;
   reg in_frame_q;
   reg drop_seen_q;
   reg [6:0] seq_raw_q;
   reg [5:0] seq_prev_q;
   reg seq_valid_q;
   reg drop_err_q, par_err_q, seq_err_q;
   reg [3:0] fsp_cnt_q;
   localparam integer FSP_CYC = `QM_FSPULSE_CYC;
   wire [5:0] seq_expect = (seq_prev_q == `QM_SEQ_MOD - 6'h01) ? 6'h00 : seq_prev_q + 6'h01;
   wire [6:0] seq_word = {seq_raw_q[5:0], vid_data_s};
   wire sync_slot = (pos_q[7:0] == 8'hff) & (pos_q != 14'h0000);

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pos_q <= 14'h0000;
         in_frame_q <= 1'b0;
         drop_seen_q <= 1'b0;
         seq_raw_q <= 7'h00;
         seq_prev_q <= 6'h00;
         seq_valid_q <= 1'b0;
         drop_err_q <= 1'b0;
         par_err_q <= 1'b0;
         seq_err_q <= 1'b0;
      end else begin
         drop_err_q <= 1'b0;
         par_err_q <= 1'b0;
         seq_err_q <= 1'b0;
         if (fs_found_q) begin
            in_frame_q <= 1'b1;
            pos_q <= 14'h0000;
            drop_seen_q <= 1'b0;
         end else if (bit_stb && in_frame_q) begin
            pos_q <= pos_q + 14'h0001;
            if (pos_q == `QM_FRAME_BITS - 14'h0001) begin
               in_frame_q <= 1'b0;
            end
            if (pos_q <= `QM_SEQ_END) begin
               seq_raw_q <= seq_word;
            end
            if (pos_q == `QM_SEQ_END) begin
               par_err_q <= (^seq_word) != `QM_SEQ_PARITY;
               seq_err_q <= seq_valid_q & (seq_word[6:1] != seq_expect);
               seq_prev_q <= seq_word[6:1];
               seq_valid_q <= 1'b1;
            end
            if (((pos_q + 14'h0001) & (`QM_SYNC_GAP - 14'h0001)) == 14'h0000 && pos_q != 14'h0000
                && shift_d != `QM_SYNC_WORD && !drop_seen_q) begin
               drop_err_q <= 1'b1;
               drop_seen_q <= 1'b1;
            end
         end
      end
   end

   // Scope markers
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         frame_mark_q <= 1'b1;
         frame_end_q <= 1'b0;
         frame_start_out_q <= 1'b0;
         fsp_cnt_q <= 4'h0;
      end else begin
         frame_mark_q <= in_frame_q | fs_found_q;
         frame_end_q <= in_frame_q & (pos_q >= `QM_FRAME_BITS - `QM_EOF_BITS);
         if (fs_found_q) begin
            fsp_cnt_q <= FSP_CYC[3:0] - 4'h1;
            frame_start_out_q <= 1'b1;
         end else if (fsp_cnt_q != 4'h0) begin
            fsp_cnt_q <= fsp_cnt_q - 4'h1;
         end else begin
            frame_start_out_q <= 1'b0;
         end
      end
   end

   qm_stretch #(.LEN(LED_CYC)) u_fs_led (.clock(clock), .rstn(rstn), .trig(fs_err_q), .out_q(fs_led));
   qm_stretch #(.LEN(LED_CYC)) u_par_led (.clock(clock), .rstn(rstn), .trig(par_err_q), .out_q(parity_led));
   qm_stretch #(.LEN(LED_CYC)) u_seq_led (.clock(clock), .rstn(rstn), .trig(seq_err_q), .out_q(seq_led));
   qm_stretch #(.LEN(LED_CYC)) u_drop_led (.clock(clock), .rstn(rstn), .trig(drop_err_q), .out_q(drop_led));

   // Integration timing and tallies
   reg [26:0] div_q;
   reg [5:0] secs_q;
   reg restart_prev_q;
   reg [9:0] fs_tally_q, seq_tally_q, drop_tally_q;
   reg [9:0] fs_disp_q, seq_disp_q, drop_disp_q;
   wire sec_tick = (div_q == SEC_CYC[26:0] - 27'h0000001);
   wire restart_rel = restart_prev_q & ~ctrl_q[`QM_CTRL_RESTART];
   wire [5:0] ivl_len = (ivl_sel == `QM_IVL_60S) ? `QM_SECS_60 :
                        (ivl_sel == `QM_IVL_10S) ? `QM_SECS_10 : `QM_SECS_1;
   wire ivl_end = sec_tick & (secs_q >= ivl_len - 6'h01);
   // Frame-count class covers both parity and sequence faults
   wire seq_any = par_err_q | seq_err_q;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_q <= 27'h0000000;
         secs_q <= 6'h00;
         restart_prev_q <= 1'b0;
         fs_tally_q <= 10'h000;
         seq_tally_q <= 10'h000;
         drop_tally_q <= 10'h000;
         fs_disp_q <= 10'h000;
         seq_disp_q <= 10'h000;
         drop_disp_q <= 10'h000;
      end else begin
         restart_prev_q <= ctrl_q[`QM_CTRL_RESTART];
         if (restart_rel) begin
            div_q <= 27'h0000000;
            secs_q <= 6'h00;
            fs_tally_q <= 10'h000;
            seq_tally_q <= 10'h000;
            drop_tally_q <= 10'h000;
         end else if (ivl_end) begin
            div_q <= 27'h0000000;
            secs_q <= 6'h00;
            fs_disp_q <= fs_tally_q;
            seq_disp_q <= seq_tally_q;
            drop_disp_q <= drop_tally_q;
            fs_tally_q <= {9'h000, fs_err_q};
            seq_tally_q <= {9'h000, seq_any};
            drop_tally_q <= {9'h000, drop_err_q};
         end else begin
            div_q <= sec_tick ? 27'h0000000 : div_q + 27'h0000001;
            if (sec_tick) begin
               secs_q <= secs_q + 6'h01;
            end
            if (fs_err_q && fs_tally_q != `QM_TALLY_MAX) begin
               fs_tally_q <= fs_tally_q + 10'h001;
            end
            if (seq_any && seq_tally_q != `QM_TALLY_MAX) begin
               seq_tally_q <= seq_tally_q + 10'h001;
            end
            if (drop_err_q && drop_tally_q != `QM_TALLY_MAX) begin
               drop_tally_q <= drop_tally_q + 10'h001;
            end
         end
      end
   end

   // Audio readout: shift on clock, latch on frame sync
   reg [35:0] aud_shift_q;
   reg [35:0] aud_disp_q;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aud_shift_q <= 36'h000000000;
         aud_disp_q <= 36'h000000000;
         aud_track2_q <= 1'b0;
      end else begin
         aud_track2_q <= ctrl_q[`QM_CTRL_TRACK2];
         if (aud_clk_s && !aud_clk_prev_q) begin
            aud_shift_q <= {aud_shift_q[34:0], aud_data_s};
         end
         if (aud_sync_s && !aud_sync_prev_q) begin
            aud_disp_q <= aud_shift_q;
         end
      end
   end

   // AXI4-Lite write: address and data taken in either order
   reg aw_have_q, w_have_q;
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg w_strb0_q;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb0_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         ctrl_q <= `QM_CTRL_RESET;
      end else begin
         s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb0_q <= s_axi_wstrb[0];
         end
         if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            // Only the control word is writable; others answer with an error
            if (aw_addr_q[7:2] == `QM_REG_CTRL >> 2) begin
               s_axi_bresp <= 2'h0;
               if (w_strb0_q) begin
                  ctrl_q <= w_data_q[5:0];
               end
            end else begin
               s_axi_bresp <= 2'h2;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read decode
   reg [31:0] rd_d;
   reg rd_ok_d;

   always @* begin
      rd_d = 32'h00000000;
      rd_ok_d = 1'b1;
      if (s_axi_araddr[7:2] == `QM_REG_CTRL >> 2) begin
         rd_d = {26'h0000000, ctrl_q};
      end else if (s_axi_araddr[7:2] == `QM_REG_STAT >> 2) begin
         rd_d = {24'h000000, 1'b0, st_q == S_IDLE, in_frame_q, win_open,
                 drop_led, seq_led, parity_led, fs_led};
      end else if (s_axi_araddr[7:2] == `QM_REG_FS_TALLY >> 2) begin
         rd_d = {22'h000000, fs_disp_q};
      end else if (s_axi_araddr[7:2] == `QM_REG_SEQ_TALLY >> 2) begin
         rd_d = {22'h000000, seq_disp_q};
      end else if (s_axi_araddr[7:2] == `QM_REG_DROP_TALLY >> 2) begin
         rd_d = {22'h000000, drop_disp_q};
      end else if (s_axi_araddr[7:2] == `QM_REG_AUD_LO >> 2) begin
         rd_d = aud_disp_q[31:0];
      end else if (s_axi_araddr[7:2] == `QM_REG_AUD_HI >> 2) begin
         rd_d = {28'h0000000, aud_disp_q[35:32]};
      end else if (s_axi_araddr[7:2] == `QM_REG_LAST_SEQ >> 2) begin
         rd_d = {26'h0000000, seq_prev_q};
      end else begin
         rd_ok_d = 1'b0;
      end
   end

   // Read channel: one read at a time, data registered
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_ok_d ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // qm_monitor
`default_nettype wire

// File: rtl/qm_stretch.v
// Retriggerable pulse stretcher driving one error indicator.
// Assumes trig is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
`default_nettype none
module qm_stretch #(
   parameter LEN = 800000
) (
   input wire clock,
   input wire rstn,
   input wire trig,
   output reg out_q
);
   // Remaining cycles of the lit period
   reg [19:0] cnt_q;

   // Each trigger reloads the full length
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 20'h00000;
         out_q <= 1'b0;
      end else if (trig) begin
         cnt_q <= LEN[19:0] - 20'h00001;
         out_q <= 1'b1;
      end else if (cnt_q != 20'h00000) begin
         cnt_q <= cnt_q - 20'h00001;
      end else begin
         out_q <= 1'b0;
      end
   end
endmodule // qm_stretch
`default_nettype wire
